// file: rtl/uhsi_defs.svh
`ifndef UHSI_DEFS_SVH
`define UHSI_DEFS_SVH

// ======================================================
// Register offsets within the controller I/O window
`define UHSI_OFS_STATUS 5'h02
`define UHSI_OFS_ENABLE 5'h04

// ======================================================
// Status bit positions
`define UHSI_ST_HALT 5
`define UHSI_ST_PERR 4
`define UHSI_ST_HERR 3
`define UHSI_ST_RSM 2
`define UHSI_ST_TERR 1
`define UHSI_ST_TINT 0

// ======================================================
// Enable bit positions
`define UHSI_EN_SHORT 3
`define UHSI_EN_IOC 2
`define UHSI_EN_RSM 1
`define UHSI_EN_TERR 0

// ======================================================
// Reset values and widths
`define UHSI_ST_W 6
`define UHSI_EN_W 4
`define UHSI_ST_RST 6'h00
`define UHSI_EN_RST 4'h0
`define UHSI_RD_RST 16'h0000
`define UHSI_HI_RST 5'h00

`endif

// file: rtl/uhsi_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhsi_defs.svh"
module uhsi_flags
   import uhsi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire uhsi_evt_t evt,
   input wire logic resume_ok,
   input wire logic halt_set,
   input wire logic [5:0] clr,
   output logic [5:0] status,
   output logic ioc_src,
   output logic short_src
);

   logic [5:1] hi_q;
   logic [5:1] hi_d;
   logic ioc_q;
   logic ioc_d;
   logic short_q;
   logic short_d;

   // ======================================================
   // Sticky flags; a set in the clearing cycle wins
   always_comb begin
      hi_d = hi_q & ~clr[5:1];
      hi_d[`UHSI_ST_HALT] = hi_d[`UHSI_ST_HALT] | halt_set;
      hi_d[`UHSI_ST_PERR] = hi_d[`UHSI_ST_PERR] | evt.proc_err;
      hi_d[`UHSI_ST_HERR] = hi_d[`UHSI_ST_HERR] | evt.host_err;
      hi_d[`UHSI_ST_RSM] = hi_d[`UHSI_ST_RSM] | (evt.resume & resume_ok);
      hi_d[`UHSI_ST_TERR] = hi_d[`UHSI_ST_TERR] | evt.txn_err;
      // Two causes share the transfer flag; kept apart for masking
      ioc_d = (ioc_q & ~clr[`UHSI_ST_TINT]) | evt.ioc_done;
      short_d = (short_q & ~clr[`UHSI_ST_TINT]) | evt.short_pkt;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_q <= `UHSI_HI_RST;
         ioc_q <= 1'b0;
         short_q <= 1'b0;
      end else begin
         hi_q <= hi_d;
         ioc_q <= ioc_d;
         short_q <= short_d;
      end
   end

   assign status = {hi_q, ioc_q | short_q};
   assign ioc_src = ioc_q;
   assign short_src = short_q;

endmodule : uhsi_flags
`default_nettype wire

// file: rtl/uhsi_halt.sv
`timescale 1ns/1ps
`default_nettype none
module uhsi_halt
   import uhsi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run_stop,
   input wire logic txn_busy,
   output logic halt_set
);

   uhsi_halt_st_t st_q;
   uhsi_halt_st_t st_d;

   // ======================================================
   // Next state; halt reported only once the bus is idle
   always_comb begin
      st_d = st_q;
      halt_set = 1'b0;
      unique case (st_q)
         UHSI_RUN: begin
            if (!run_stop) begin
               st_d = UHSI_DRAIN;
            end
         end
         UHSI_DRAIN: begin
            if (run_stop) begin
               st_d = UHSI_RUN;
            end else if (!txn_busy) begin
               st_d = UHSI_HALT;
               halt_set = 1'b1;
            end
         end
         UHSI_HALT: begin
            if (run_stop) begin
               st_d = UHSI_RUN;
            end
         end
         default: begin
            st_d = UHSI_HALT;
         end
      endcase
   end

   // Reset lands in the stopped state without raising the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= UHSI_HALT;
      end else begin
         st_q <= st_d;
      end
   end

endmodule : uhsi_halt
`default_nettype wire

// file: rtl/uhsi_pkg.sv
package uhsi_pkg;

   // ======================================================
   // Event strobes from the schedule walker, one cycle each
   typedef struct packed {
      logic proc_err;
      logic host_err;
      logic resume;
      logic txn_err;
      logic ioc_done;
      logic short_pkt;
   } uhsi_evt_t;

   // ======================================================
   // Halt tracking, Gray coded along run, drain, halt
   typedef enum logic [1:0] {
      UHSI_RUN = 2'h0,
      UHSI_DRAIN = 2'h1,
      UHSI_HALT = 2'h3
   } uhsi_halt_st_t;

   function automatic logic uhsi_hit(
      input logic [4:0] addr,
      input logic [4:0] ofs
   );
      uhsi_hit = (addr == ofs);
   endfunction : uhsi_hit

endpackage : uhsi_pkg

// file: rtl/uhsi_top.sv
// Notes on behaviour
// - Writing 1 to a status bit clears it; writing 0 keeps it.
// - Halted flag bit 5 sets once stopped after run/stop went low.
// - Process-error flag bit 4 sets on a descriptor consistency failure.
// - Process error clears run/stop and always raises the interrupt.
// - Host-system-error flag bit 3 sets on a host bus access failure.
// - Host system error clears run/stop and raises the interrupt.
// - Resume flag bit 2 sets on resume only during global suspend.
// - Transaction error sets bit 1; with completion request bit 0 too.
// - Transfer flag bit 0 sets when a notify-on-complete descriptor ends.
// - Transfer flag also sets on a short packet with detection enabled.
// - Interrupt asserts whenever an enabled source is active.
// - Process-error interrupt cannot be masked.
// - Disabled sources still set their status flags for polling.
// - Enables: short bit 3, completion bit 2, resume 1, error 0.
// - Status and enable registers reset to all zeros.
// - Halted reports only after the transaction in progress finishes.
`timescale 1ns/1ps
`default_nettype none
`include "uhsi_defs.svh"
module uhsi_top
   import uhsi_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [4:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [1:0] IO_BE,
   input wire logic [15:0] IO_WDATA,
   output logic [15:0] IO_RDATA,
   input wire uhsi_evt_t EVT,
   input wire logic GLOBAL_SUSPEND,
   input wire logic RUN_STOP,
   input wire logic TXN_BUSY,
   output logic RS_CLEAR,
   output logic IRQ
);

   // ======================================================
   // Reset release
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   // Release is synchronised so all flags leave reset together
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   // ======================================================
   // Register port decode
   logic wr_st;
   logic wr_en;
   logic rd_st;
   logic rd_en;
   logic [5:0] clr;

   // All live bits sit in the low byte, so only lane 0 matters
   assign wr_st = IO_WR & IO_BE[0]
                & uhsi_hit(IO_ADDR, `UHSI_OFS_STATUS);
   assign wr_en = IO_WR & IO_BE[0]
                & uhsi_hit(IO_ADDR, `UHSI_OFS_ENABLE);
   assign rd_st = uhsi_hit(IO_ADDR, `UHSI_OFS_STATUS);
   assign rd_en = uhsi_hit(IO_ADDR, `UHSI_OFS_ENABLE);
   assign clr = wr_st ? IO_WDATA[5:0] : `UHSI_ST_RST;

   // ======================================================
   // Halt tracking and sticky flags
   logic halt_set;
   logic [5:0] st;
   logic ioc_src;
   logic short_src;

   uhsi_halt u_halt (
      .clk(CLK),
      .rst_n(rst_n),
      .run_stop(RUN_STOP),
      .txn_busy(TXN_BUSY),
      .halt_set(halt_set)
   );

   uhsi_flags u_flags (
      .clk(CLK),
      .rst_n(rst_n),
      .evt(EVT),
      .resume_ok(GLOBAL_SUSPEND),
      .halt_set(halt_set),
      .clr(clr),
      .status(st),
      .ioc_src(ioc_src),
      .short_src(short_src)
   );

   // ======================================================
   // Enable register, read data, run/stop clear, interrupt
   logic [3:0] en_q;
   logic [3:0] en_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic rs_clr_q;
   logic rs_clr_d;
   logic irq_q;
   logic irq_d;

   always_comb begin
      en_d = en_q;
      if (wr_en) begin
         en_d = IO_WDATA[3:0];
      end
      rdata_d = rdata_q;
      if (IO_RD) begin
         rdata_d = `UHSI_RD_RST;
         if (rd_st) begin
            rdata_d[5:0] = st;
         end else if (rd_en) begin
            rdata_d[3:0] = en_q;
         end
      end
      // Fatal errors stop the schedule walker at once
      rs_clr_d = EVT.proc_err | EVT.host_err;
      // Halted has no enable and never interrupts by itself
      irq_d = st[`UHSI_ST_PERR]
            | st[`UHSI_ST_HERR]
            | (st[`UHSI_ST_RSM] & en_q[`UHSI_EN_RSM])
            | (st[`UHSI_ST_TERR] & en_q[`UHSI_EN_TERR])
            | (ioc_src & en_q[`UHSI_EN_IOC])
            | (short_src & en_q[`UHSI_EN_SHORT]);
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= `UHSI_EN_RST;
         rdata_q <= `UHSI_RD_RST;
         rs_clr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         en_q <= en_d;
         rdata_q <= rdata_d;
         rs_clr_q <= rs_clr_d;
         irq_q <= irq_d;
      end
   end

   assign IO_RDATA = rdata_q;
   assign RS_CLEAR = rs_clr_q;
   assign IRQ = irq_q;

   // ======================================================
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   w1c_clear_a: assert property (
      wr_st && IO_WDATA[`UHSI_ST_PERR] && !EVT.proc_err
      |=> !st[`UHSI_ST_PERR])
      else $error("status bit not cleared by write of one");

   w0_keep_a: assert property (
      wr_st && !IO_WDATA[`UHSI_ST_HERR] && st[`UHSI_ST_HERR]
      |=> st[`UHSI_ST_HERR])
      else $error("status bit lost on write of zero");

   set_wins_a: assert property (
      wr_st && IO_WDATA[`UHSI_ST_TERR] && EVT.txn_err
      |=> st[`UHSI_ST_TERR])
      else $error("event lost against a clear");

   halt_flag_a: assert property (
      halt_set |=> st[`UHSI_ST_HALT])
      else $error("halted flag not set on stop");

   halt_busy_a: assert property (
      TXN_BUSY |-> !halt_set)
      else $error("halt reported during a transaction");

   halt_stop_a: assert property (
      $fell(RUN_STOP) ##1 (!RUN_STOP && !TXN_BUSY)
      |=> st[`UHSI_ST_HALT])
      else $error("halt not reported after idle stop");

   perr_flag_a: assert property (
      EVT.proc_err |=> st[`UHSI_ST_PERR])
      else $error("process error flag not set");

   perr_stop_a: assert property (
      EVT.proc_err |=> RS_CLEAR)
      else $error("process error did not clear run");

   fatal_irq_a: assert property (
      EVT.proc_err && en_q == `UHSI_EN_RST |-> ##2 IRQ)
      else $error("process error interrupt masked");

   herr_stop_a: assert property (
      EVT.host_err |=> RS_CLEAR && st[`UHSI_ST_HERR])
      else $error("host error not flagged or run kept");

   herr_irq_a: assert property (
      EVT.host_err |-> ##2 IRQ)
      else $error("host error did not interrupt");

   rs_quiet_a: assert property (
      !EVT.proc_err && !EVT.host_err |=> !RS_CLEAR)
      else $error("run cleared without fatal error");

   rsm_gate_a: assert property (
      !st[`UHSI_ST_RSM] && !(EVT.resume && GLOBAL_SUSPEND)
      |=> !st[`UHSI_ST_RSM])
      else $error("resume flag set outside suspend");

   rsm_set_a: assert property (
      EVT.resume && GLOBAL_SUSPEND && !en_q[`UHSI_EN_RSM]
      |=> st[`UHSI_ST_RSM])
      else $error("resume flag missing while disabled");

   terr_both_a: assert property (
      EVT.txn_err && EVT.ioc_done
      |=> st[`UHSI_ST_TERR] && st[`UHSI_ST_TINT])
      else $error("error with completion not both set");

   ioc_flag_a: assert property (
      EVT.ioc_done |=> st[`UHSI_ST_TINT])
      else $error("completion flag not set");

   short_flag_a: assert property (
      EVT.short_pkt |=> st[`UHSI_ST_TINT])
      else $error("short packet flag not set");

   rsm_irq_a: assert property (
      st[`UHSI_ST_RSM] && en_q[`UHSI_EN_RSM] |=> IRQ)
      else $error("enabled resume did not interrupt");

   short_mask_a: assert property (
      st == 6'h01 && !ioc_src && !en_q[`UHSI_EN_SHORT]
      |=> !IRQ)
      else $error("masked short packet interrupted");

   irq_quiet_a: assert property (
      en_q == `UHSI_EN_RST && st[4:3] == 2'h0 |=> !IRQ)
      else $error("interrupt with all sources masked");

   en_write_a: assert property (
      wr_en |=> en_q == $past(IO_WDATA[3:0]))
      else $error("enable register write lost");

   rst_zero_a: assert property (
      $rose(rst_n) |-> st == `UHSI_ST_RST && en_q == `UHSI_EN_RST)
      else $error("registers not zero after reset");

   rsv_read_a: assert property (
      IO_RD |=> IO_RDATA[15:6] == 10'h000)
      else $error("reserved status bits read nonzero");

   rsv_en_a: assert property (
      IO_RD && rd_en |=> IO_RDATA[15:4] == 12'h000)
      else $error("reserved enable bits read nonzero");

   terr_flag_a: assert property (
      EVT.txn_err |=> st[`UHSI_ST_TERR])
      else $error("transaction error flag not set");

   ioc_irq_a: assert property (
      EVT.ioc_done && en_q[`UHSI_EN_IOC] && !wr_en
      |-> ##2 IRQ)
      else $error("enabled completion did not interrupt");

   short_irq_a: assert property (
      EVT.short_pkt && en_q[`UHSI_EN_SHORT] && !wr_en
      |-> ##2 IRQ)
      else $error("enabled short packet did not interrupt");

   terr_irq_a: assert property (
      st[`UHSI_ST_TERR] && en_q[`UHSI_EN_TERR] |=> IRQ)
      else $error("enabled transaction error did not interrupt");

   ioc_mask_a: assert property (
      st == 6'h01 && !short_src && !en_q[`UHSI_EN_IOC]
      |=> !IRQ)
      else $error("masked completion interrupted");

   rsm_mask_a: assert property (
      st == 6'h04 && !en_q[`UHSI_EN_RSM]
      |=> !IRQ)
      else $error("masked resume interrupted");

   terr_mask_a: assert property (
      st == 6'h02 && !en_q[`UHSI_EN_TERR]
      |=> !IRQ)
      else $error("masked transaction error interrupted");

   halt_quiet_a: assert property (
      st == 6'h20 |=> !IRQ)
      else $error("halted flag alone interrupted");

   perr_irq_a: assert property (
      st[`UHSI_ST_PERR] |=> IRQ)
      else $error("process error interrupt was masked");

   herr_level_a: assert property (
      st[`UHSI_ST_HERR] |=> IRQ)
      else $error("host error interrupt was masked");

   rd_status_a: assert property (
      IO_RD && rd_st |=> IO_RDATA[5:0] == $past(st))
      else $error("status read does not show the flags");

   rd_enable_a: assert property (
      IO_RD && rd_en |=> IO_RDATA[3:0] == $past(en_q))
      else $error("enable read does not show the mask");

   rd_unmap_a: assert property (
      IO_RD && !rd_st && !rd_en
      |=> IO_RDATA == `UHSI_RD_RST)
      else $error("unmapped read returned nonzero");

   en_hold_a: assert property (
      !wr_en |=> $stable(en_q))
      else $error("enable register changed without a write");

   halt_run_a: assert property (
      halt_set |-> !RUN_STOP)
      else $error("halt reported while running");

   sticky_hold_a: assert property (
      !wr_st |=> (st & $past(st)) == $past(st))
      else $error("status flag dropped without a clear");

   halt_only_a: assert property (
      !halt_set && !st[`UHSI_ST_HALT] |=> !st[`UHSI_ST_HALT])
      else $error("halted flag set without a stop");

   w1c_halt_a: assert property (
      wr_st && IO_WDATA[`UHSI_ST_HALT] && !halt_set
      |=> !st[`UHSI_ST_HALT])
      else $error("halted flag not cleared by write of one");

   w1c_tint_a: assert property (
      wr_st && IO_WDATA[`UHSI_ST_TINT]
      && !EVT.ioc_done && !EVT.short_pkt
      |=> !st[`UHSI_ST_TINT])
      else $error("transfer flag not cleared by write of one");

endmodule : uhsi_top
`default_nettype wire

// file: tb/test_usb_host_status_irq.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_host_status_irq
   import uhsi_pkg::*;
;
   // ==================================================
   // Stimulus signals
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] addr = 5'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] be = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   uhsi_evt_t evt = '0;
   logic susp = 1'b0;
   logic run = 1'b0;
   logic busy = 1'b0;
   logic rs_clear;
   logic irq;
   logic drive = 1'b0;
   logic live = 1'b0;
   logic seeded = 1'b0;
   int fails = 0;
   int comparisons = 0;
   // Behavioural model state
   int st, en, ioc_c, sh_c, hs, rdat, rsc, irq_m;

   uhsi_top i_uhsi_top (
      .CLK(clk), .RST_B(rst_b), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd),
      .IO_BE(be), .IO_WDATA(wdata), .IO_RDATA(rdata), .EVT(evt),
      .GLOBAL_SUSPEND(susp), .RUN_STOP(run), .TXN_BUSY(busy),
      .RS_CLEAR(rs_clear), .IRQ(irq)
   );

   always #5 clk = ~clk;

   // ==================================================
   // Model, updated from the values sampled at each edge
   always @(posedge clk or negedge rst_b) begin
      int clr;
      int set;
      if (!rst_b) begin
         st = 0;
         en = 0;
         ioc_c = 0;
         sh_c = 0;
         hs = 2;
         rdat = 0;
         rsc = 0;
         irq_m = 0;
      end else begin
         clr = (wr && be[0] && addr == 5'h02) ? int'(wdata[5:0]) : 0;
         irq_m = ((st >> 4) & 1) | ((st >> 3) & 1)
            | ((st >> 2) & (en >> 1) & 1)
            | ((st >> 1) & en & 1) | (ioc_c & (en >> 2) & 1)
            | (sh_c & (en >> 3) & 1);
         rsc = evt.proc_err | evt.host_err;
         if (rd) rdat = (addr == 5'h02) ? st : (addr == 5'h04) ? en : 0;
         set = {evt.proc_err, evt.host_err, evt.resume & susp, evt.txn_err,
            evt.ioc_done | evt.short_pkt};
         // Drain waits for the bus to go idle before halting
         if (hs == 1 && run) begin
            hs = 0;
         end else if (hs == 1 && !busy) begin
            set = set | 32;
            hs = 2;
         end else if (hs != 1 && run) begin
            hs = 0;
         end else if (hs == 0 && !run) begin
            hs = 1;
         end
         st = (st & ~clr & 63) | set;
         ioc_c = (ioc_c & ~clr & 1) | evt.ioc_done;
         sh_c = (sh_c & ~clr & 1) | evt.short_pkt;
         if (wr && be[0] && addr == 5'h04) en = wdata[3:0];
      end
   end

   // ==================================================
   // Random stimulus; one bus request per cycle at most
   always @(posedge clk) begin
      int r;
      logic [5:0] e;
      // Seeded here, as this is the process that draws the numbers
      if (!seeded) begin
         void'($urandom(32'hfb44_3b90));
         seeded = 1'b1;
      end
      r = $urandom % 8;
      for (int i = 0; i < 6; i++) e[i] = ($urandom % 16) == 0;
      if (drive) begin
         wr <= r < 2;
         rd <= r == 2 || r == 3;
         addr <= ($urandom % 4 == 3) ? 5'($urandom) :
            (($urandom % 2) ? 5'h02 : 5'h04);
         be <= ($urandom % 4 == 0) ? 2'h2 : 2'h3;
         wdata <= 16'($urandom);
         evt <= uhsi_evt_t'(e);
         busy <= ($urandom % 3) == 0;
         if ($urandom % 32 == 0) run <= ~run;
         if ($urandom % 64 == 0) susp <= ~susp;
      end else begin
         wr <= 1'b0;
         rd <= 1'b0;
         evt <= '0;
         busy <= 1'b0;
         run <= 1'b0;
      end
   end

   // ==================================================
   // Checks, made where outputs have settled
   task automatic chk(input logic [15:0] got, input int exp, input string w);
      comparisons++;
      if (got !== exp[15:0]) begin
         fails++;
         $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp[15:0]);
      end
   endtask : chk

   always @(negedge clk) begin
      if (live) begin
         chk(rdata & 16'h0038, rdat & 56, "rd 5:3");
         chk(rdata & 16'h0007, rdat & 7, "rd 2:0");
         chk(rdata & 16'hffc0, 0, "rd 15:6");
         chk({15'h0000, irq}, irq_m, "irq");
         chk({15'h0000, rs_clear}, rsc, "run/stop clear");
      end
   end

   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // Two random phases with a reset between them
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      live = 1'b1;
      drive <= 1'b1;
      repeat (3000) @(posedge clk);
      live = 1'b0;
      drive <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      live = 1'b1;
      drive <= 1'b1;
      repeat (3000) @(posedge clk);
      finish_test();
   end

   // Run should end near 60 us; far beyond that means a hang
   initial begin
      #200000;
      fails++;
      finish_test();
   end
endmodule : test_usb_host_status_irq
`default_nettype wire
